// ### rtl/htc_top.sv
// Call controller of a hardware thread: serves user opcodes with bus-master
// transfers and keeps the system and call status in step.
// Assumes system-slave, bus and user-logic signals share core_clk; nrst is asynchronous.

`default_nettype none

module htc_top #(
	parameter logic [31:0] FINISH_BASE = 32'h0001_0000,
	parameter logic [31:0] ACQUIRE_BASE = 32'h0002_0000,
	parameter logic [31:0] RELEASE_BASE = 32'h0003_0000
) (
	input wire logic core_clk,
	input wire logic nrst,
	// System-side slave events
	input wire logic tid_wr,
	input wire logic [htc_pkg::TID_W-1:0] thread_ident_reg,
	input wire logic cmd_run,
	input wire logic cmd_reset,
	input wire logic [htc_pkg::DATA_W-1:0] sys_arg_in,
	output logic cmd_ack,
	output htc_pkg::htc_sys_st_t sys_status,
	// Bus master
	output logic master_req,
	output logic master_rnw,
	output logic [htc_pkg::DATA_W-1:0] master_addr_out,
	output logic [htc_pkg::DATA_W-1:0] master_wdata_out,
	input wire logic [htc_pkg::DATA_W-1:0] master_rdata_in,
	input wire logic master_ack,
	// Thread user logic
	input wire logic [htc_pkg::OP_W-1:0] user_opcode,
	input wire logic [htc_pkg::DATA_W-1:0] user_arg1,
	input wire logic [htc_pkg::DATA_W-1:0] user_arg2,
	output htc_pkg::htc_call_st_t call_status,
	output logic [htc_pkg::DATA_W-1:0] call_result,
	output logic user_rst
);

	typedef enum logic [3:0] {
		C_START = 4'h0,
		C_NOT_USED = 4'h1,
		C_NU_WAIT = 4'h3,
		C_USED = 4'h2,
		C_USED_WAIT = 4'h6,
		C_RUNNING = 4'h7,
		C_BUS = 4'h5,
		C_DONE_WAIT = 4'h4,
		C_BLOCKED = 4'hC,
		C_HALT = 4'hD
	} htc_cst_t;

	logic rst_meta_q;
	logic rst_n;
	logic soft_rst_q;
	htc_cst_t st_q;
	htc_cst_t st_d;
	htc_pkg::htc_sys_req_t sreq_q;
	htc_pkg::htc_sys_req_t sreq_set;
	htc_pkg::htc_user_req_t ureq_q;
	logic ureq_set;
	logic bus_go;
	logic bus_rd;
	logic [htc_pkg::DATA_W-1:0] bus_addr;
	logic res_ld;
	logic [htc_pkg::DATA_W-1:0] res_val;
	logic [htc_pkg::DATA_W-1:0] result_q;
	logic [htc_pkg::OP_W-1:0] opcode;
	logic [htc_pkg::DATA_W-1:0] arg1;
	logic [htc_pkg::DATA_W-1:0] arg2;
	logic [htc_pkg::LOCK_W-1:0] lock_num;
	logic bus_done;
	htc_pkg::htc_call_st_t call_st;
	htc_pkg::htc_sys_st_t sys_st;

	// ----------------------------------------
	// Reset release and reset command
	// ----------------------------------------

	// Two-stage release of the asynchronous reset
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// Acknowledge the command first, reset the machines one cycle later
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ack <= 1'b0;
			soft_rst_q <= 1'b0;
		end else begin
			cmd_ack <= cmd_reset;
			soft_rst_q <= cmd_ack;
		end
	end

	// ----------------------------------------
	// Companion machines
	// ----------------------------------------
	htc_user_fsm u_user (
		.clk(core_clk),
		.rst_n(rst_n),
		.soft_rst(soft_rst_q),
		.ureq(ureq_q),
		.opcode_in(user_opcode),
		.arg1_in(user_arg1),
		.arg2_in(user_arg2),
		.call_status_q(call_st),
		.opcode_q(opcode),
		.arg1_q(arg1),
		.arg2_q(arg2)
	);

	htc_sys_status u_sys (
		.clk(core_clk),
		.rst_n(rst_n),
		.soft_rst(soft_rst_q),
		.sreq(sreq_q),
		.sys_status_q(sys_st)
	);

	assign call_status = call_st;
	assign sys_status = sys_st;
	assign call_result = result_q;
	assign lock_num = arg1[htc_pkg::LOCK_HI:htc_pkg::LOCK_LO];
	assign bus_done = master_req && master_ack;

	// ----------------------------------------
	// Controller next state
	// ----------------------------------------

	// Decode events into requests, bus starts and result loads
	always_comb begin
		st_d = st_q;
		sreq_set = htc_pkg::SR_NOOP;
		ureq_set = 1'b0;
		bus_go = 1'b0;
		bus_rd = 1'b1;
		bus_addr = htc_pkg::WORD_RST;
		res_ld = 1'b0;
		res_val = result_q;
		case (st_q)
			C_START: begin
				st_d = C_NOT_USED;
			end
			C_NOT_USED: begin
				if (tid_wr) begin
					sreq_set = htc_pkg::SR_USED;
					st_d = C_NU_WAIT;
				end
			end
			C_NU_WAIT: begin
				if (sreq_q == htc_pkg::SR_NOOP) begin
					st_d = C_USED;
				end
			end
			C_USED: begin
				if (cmd_run) begin
					sreq_set = htc_pkg::SR_RUN;
					ureq_set = 1'b1;
					res_ld = 1'b1;
					res_val = sys_arg_in;
					st_d = C_USED_WAIT;
				end
			end
			C_USED_WAIT: begin
				if (sreq_q == htc_pkg::SR_NOOP && ureq_q == htc_pkg::UR_NOOP) begin
					st_d = C_RUNNING;
				end
			end
			C_RUNNING: begin
				if (call_st == htc_pkg::CS_ACK && ureq_q == htc_pkg::UR_NOOP) begin
					case (opcode)
						htc_pkg::OP_READ: begin
							bus_go = 1'b1;
							bus_addr = arg1;
							st_d = C_BUS;
						end
						htc_pkg::OP_WRITE: begin
							bus_go = 1'b1;
							bus_rd = 1'b0;
							bus_addr = arg1;
							st_d = C_BUS;
						end
						htc_pkg::OP_EXIT, htc_pkg::OP_EXIT_ERR: begin
							bus_go = 1'b1;
							bus_addr = htc_pkg::call_addr(FINISH_BASE, '0, thread_ident_reg);
							st_d = C_BUS;
						end
						htc_pkg::OP_LOCK: begin
							bus_go = 1'b1;
							bus_addr = htc_pkg::call_addr(ACQUIRE_BASE, lock_num, thread_ident_reg);
							st_d = C_BUS;
						end
						htc_pkg::OP_UNLOCK: begin
							bus_go = 1'b1;
							bus_addr = htc_pkg::call_addr(RELEASE_BASE, lock_num, thread_ident_reg);
							st_d = C_BUS;
						end
						htc_pkg::OP_SELF: begin
							res_ld = 1'b1;
							res_val = {{(htc_pkg::DATA_W-htc_pkg::TID_W){1'b0}}, thread_ident_reg};
							ureq_set = 1'b1;
							st_d = C_DONE_WAIT;
						end
						default: begin
							ureq_set = 1'b1;
							st_d = C_DONE_WAIT;
						end
					endcase
				end
			end
			C_BUS: begin
				if (bus_done) begin
					case (opcode)
						htc_pkg::OP_READ: begin
							res_ld = 1'b1;
							res_val = master_rdata_in;
							ureq_set = 1'b1;
							st_d = C_DONE_WAIT;
						end
						htc_pkg::OP_EXIT: begin
							sreq_set = htc_pkg::SR_EXIT;
							st_d = C_HALT;
						end
						htc_pkg::OP_EXIT_ERR: begin
							sreq_set = htc_pkg::SR_EXIT_ERR;
							st_d = C_HALT;
						end
						htc_pkg::OP_LOCK: begin
							if (master_rdata_in[htc_pkg::GRANT_BIT]) begin
								ureq_set = 1'b1;
								st_d = C_DONE_WAIT;
							end else begin
								sreq_set = htc_pkg::SR_BLOCK;
								st_d = C_BLOCKED;
							end
						end
						default: begin
							ureq_set = 1'b1;
							st_d = C_DONE_WAIT;
						end
					endcase
				end
			end
			C_DONE_WAIT: begin
				if (ureq_q == htc_pkg::UR_NOOP) begin
					st_d = C_RUNNING;
				end
			end
			C_BLOCKED: begin
				if (cmd_run && sreq_q == htc_pkg::SR_NOOP) begin
					sreq_set = htc_pkg::SR_RUN;
					ureq_set = 1'b1;
					st_d = C_DONE_WAIT;
				end
			end
			C_HALT: begin
				st_d = C_HALT;
			end
			default: begin
				st_d = C_START;
			end
		endcase
	end

	// ----------------------------------------
	// Controller registers
	// ----------------------------------------

	// State register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= C_START;
		end else if (soft_rst_q) begin
			st_q <= C_START;
		end else begin
			st_q <= st_d;
		end
	end

	// Status requests: held until honoured, a new request wins over the clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sreq_q <= htc_pkg::SR_NOOP;
			ureq_q <= htc_pkg::UR_NOOP;
		end else if (soft_rst_q) begin
			sreq_q <= htc_pkg::SR_NOOP;
			ureq_q <= htc_pkg::UR_NOOP;
		end else begin
			if (sreq_set != htc_pkg::SR_NOOP) begin
				sreq_q <= sreq_set;
			end else if (sreq_q != htc_pkg::SR_NOOP && sys_st == htc_pkg::req_target(sreq_q)) begin
				sreq_q <= htc_pkg::SR_NOOP;
			end
			if (ureq_set) begin
				ureq_q <= htc_pkg::UR_ASK_SET_RUN;
			end else if (call_st == htc_pkg::CS_RUN) begin
				ureq_q <= htc_pkg::UR_NOOP;
			end
		end
	end

	// Bus master: request held until the bus acknowledges
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			master_req <= 1'b0;
			master_rnw <= 1'b1;
			master_addr_out <= htc_pkg::WORD_RST;
			master_wdata_out <= htc_pkg::WORD_RST;
		end else if (soft_rst_q) begin
			master_req <= 1'b0;
		end else if (bus_go) begin
			master_req <= 1'b1;
			master_rnw <= bus_rd;
			master_addr_out <= bus_addr;
			master_wdata_out <= arg2;
		end else if (bus_done) begin
			master_req <= 1'b0;
		end
	end

	// Result register, written by the controller only
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= htc_pkg::RESULT_RST;
		end else if (soft_rst_q) begin
			result_q <= htc_pkg::RESULT_RST;
		end else if (res_ld) begin
			result_q <= res_val;
		end
	end

	// Reset seen by the user logic while the call status is RESET
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			user_rst <= 1'b1;
		end else begin
			user_rst <= soft_rst_q || (call_st == htc_pkg::CS_RESET);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n || soft_rst_q);

	sequence self_call;
		st_q == C_RUNNING && call_st == htc_pkg::CS_ACK && ureq_q == htc_pkg::UR_NOOP
			&& opcode == htc_pkg::OP_SELF;
	endsequence

	sequence bus_end(logic [htc_pkg::OP_W-1:0] op);
		st_q == C_BUS && bus_done && opcode == op;
	endsequence

	AST_RUN_REQ_HELD: assert property ((ureq_q == htc_pkg::UR_ASK_SET_RUN && call_st != htc_pkg::CS_RUN)
		|=> ureq_q == htc_pkg::UR_ASK_SET_RUN)
		else $error("run request dropped early");
	AST_RUN_REQ_CLEARED: assert property ((ureq_q == htc_pkg::UR_ASK_SET_RUN && call_st == htc_pkg::CS_RUN)
		|=> ureq_q == htc_pkg::UR_NOOP)
		else $error("run request not cleared");
	AST_SYS_REQ_HELD: assert property ((sreq_q != htc_pkg::SR_NOOP && sys_st != htc_pkg::req_target(sreq_q))
		|=> $stable(sreq_q))
		else $error("system request changed before honoured");
	AST_SELF_RESULT: assert property (self_call |=> (result_q[htc_pkg::DATA_W-1:htc_pkg::TID_W] == '0
		&& result_q[htc_pkg::TID_W-1:0] == $past(thread_ident_reg)) ##1 call_st == htc_pkg::CS_RUN)
		else $error("identity call result or timing wrong");
	AST_READ_LOAD: assert property (bus_end(htc_pkg::OP_READ) |=> result_q == $past(master_rdata_in))
		else $error("read data not loaded");
	AST_WRITE_KEEP: assert property (bus_end(htc_pkg::OP_WRITE) |=> $stable(result_q) && !master_rnw)
		else $error("write changed result");
	AST_FINISH_EXIT: assert property (bus_end(htc_pkg::OP_EXIT) |=> ##1 sys_st == htc_pkg::SS_EXITED)
		else $error("finish did not reach EXITED");
	AST_LOCK_REFUSED: assert property ((bus_end(htc_pkg::OP_LOCK) and !master_rdata_in[htc_pkg::GRANT_BIT])
		|=> sreq_q == htc_pkg::SR_BLOCK ##1 (sys_st == htc_pkg::SS_BLOCKED && call_st == htc_pkg::CS_ACK))
		else $error("refused lock not blocked");
	AST_TID_USED: assert property ((st_q == C_NOT_USED && tid_wr) |=> sreq_q == htc_pkg::SR_USED)
		else $error("identity write did not request USED");
	AST_BUS_HOLD: assert property ((master_req && !master_ack) |=> master_req && $stable(master_addr_out))
		else $error("bus request not held");
	AST_RESET_ORDER: assert property (disable iff (!rst_n) cmd_reset |=> cmd_ack ##1 soft_rst_q)
		else $error("reset before acknowledge");

endmodule : htc_top

`default_nettype wire

// ### rtl/htc_pkg.sv
// Shared constants, encodings and helpers of the hardware-thread call controller.
// Assumes one clock domain; every user of these names writes htc_pkg::name.
//
// What this block does
// - User machine writes status, opcode, arguments; controller writes result.
// - User request is only ask_set_run or no-op.
// - Hold ask_set_run until status is RUN, then clear.
// - Reset gives status RESET until RUN; user logic resets.
// - After RUN, wait two cycles before new opcode.
// - Controller drives bus master and coordinates status changes.
// - Request USED, RUNNING, EXITED, BLOCKED on their events.
// - Opcode gives ACK; controller serves, then asks RUN.
// - Finish call reads scheduler with identity; then EXITED.
// - Finish read data ignored; always treated as success.
// - Error finish same read, status becomes error-exit.
// - READ reads at argument one into result.
// - WRITE writes argument two at argument one; result kept.
// - Own-identity call zero-extends identity into result.
// - Own-identity: RUN the cycle after result written.
// - Give-way call: no bus, ACK then RUN.
// - Lock acquire reads arbiter, lock bits 31:26 and identity.
// - Granted lock gives RUN; refused gives ACK and BLOCKED.
// - Blocked waits RUN command, then RUNNING and RUN.
// - Lock release reads arbiter, then RUN.
// - Interrupt-association call does no bus action.
// - System request register encodings held until honoured.
// - Reset command acknowledged before state machines reset.

`default_nettype none

package htc_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int TID_W = 8;
	localparam int DATA_W = 32;
	localparam int OP_W = 6;
	localparam int LOCK_W = 6;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int LOCK_HI = 31; // Lock number field in argument one
	localparam int LOCK_LO = 26;
	localparam int GRANT_BIT = 0; // Grant flag in acquire read data
	localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
	localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
	localparam logic [TID_W-1:0] TID_RST = 8'h00;
	localparam logic [1:0] RUN_HOLD_CYC = 2'h2; // Cycles held in RUN before accepting

	// ----------------------------------------
	// Opcodes placed by the user logic
	// ----------------------------------------
	localparam logic [OP_W-1:0] OP_NOP = 6'h00;
	localparam logic [OP_W-1:0] OP_READ = 6'h01;
	localparam logic [OP_W-1:0] OP_WRITE = 6'h02;
	localparam logic [OP_W-1:0] OP_EXIT = 6'h03;
	localparam logic [OP_W-1:0] OP_EXIT_ERR = 6'h04;
	localparam logic [OP_W-1:0] OP_SELF = 6'h05;
	localparam logic [OP_W-1:0] OP_YIELD = 6'h06;
	localparam logic [OP_W-1:0] OP_LOCK = 6'h07;
	localparam logic [OP_W-1:0] OP_UNLOCK = 6'h08;
	localparam logic [OP_W-1:0] OP_INTR_ASSOC = 6'h09;

	// ----------------------------------------
	// Status and request encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		CS_RESET = 2'h0,
		CS_RUN = 2'h1,
		CS_ACK = 2'h3
	} htc_call_st_t;

	typedef enum logic [2:0] {
		SS_NOT_USED = 3'h0,
		SS_USED = 3'h1,
		SS_RUNNING = 3'h2,
		SS_EXITED = 3'h3,
		SS_EXIT_ERR = 3'h4,
		SS_BLOCKED = 3'h5
	} htc_sys_st_t;

	typedef enum logic [2:0] {
		SR_NOOP = 3'h0,
		SR_USED = 3'h1,
		SR_RUN = 3'h2,
		SR_EXIT = 3'h3,
		SR_EXIT_ERR = 3'h4,
		SR_BLOCK = 3'h5
	} htc_sys_req_t;

	typedef enum logic {
		UR_NOOP = 1'h0,
		UR_ASK_SET_RUN = 1'h1
	} htc_user_req_t;

	// Status that a system request asks for
	function automatic htc_sys_st_t req_target(input htc_sys_req_t r);
		case (r)
			SR_USED: req_target = SS_USED;
			SR_RUN: req_target = SS_RUNNING;
			SR_EXIT: req_target = SS_EXITED;
			SR_EXIT_ERR: req_target = SS_EXIT_ERR;
			SR_BLOCK: req_target = SS_BLOCKED;
			default: req_target = SS_NOT_USED;
		endcase
	endfunction : req_target

	// Register address with lock number and identity embedded
	function automatic logic [DATA_W-1:0] call_addr(input logic [DATA_W-1:0] base,
		input logic [LOCK_W-1:0] lock, input logic [TID_W-1:0] tid);
		call_addr = base | {16'h0000, lock, tid, 2'h0};
	endfunction : call_addr

endpackage : htc_pkg

`default_nettype wire

// ### rtl/htc_sys_status.sv
// System-side status keeper: applies the controller's status requests.
// Assumes requests arrive from the controller on the same clock.

`default_nettype none

module htc_sys_status (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_rst,
	input wire htc_pkg::htc_sys_req_t sreq,
	output htc_pkg::htc_sys_st_t sys_status_q
);

	// ----------------------------------------
	// Status register
	// ----------------------------------------

	// Honour any pending request in one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_status_q <= htc_pkg::SS_NOT_USED;
		end else if (soft_rst) begin
			sys_status_q <= htc_pkg::SS_NOT_USED;
		end else if (sreq != htc_pkg::SR_NOOP) begin
			sys_status_q <= htc_pkg::req_target(sreq);
		end
	end

endmodule : htc_sys_status

`default_nettype wire

// ### rtl/htc_user_fsm.sv
// User-side state machine: owns call status, opcode and both arguments.
// Assumes the user logic is on the same clock and keeps its opcode until ACK.

`default_nettype none

module htc_user_fsm (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_rst,
	input wire htc_pkg::htc_user_req_t ureq,
	input wire logic [htc_pkg::OP_W-1:0] opcode_in,
	input wire logic [htc_pkg::DATA_W-1:0] arg1_in,
	input wire logic [htc_pkg::DATA_W-1:0] arg2_in,
	output htc_pkg::htc_call_st_t call_status_q,
	output logic [htc_pkg::OP_W-1:0] opcode_q,
	output logic [htc_pkg::DATA_W-1:0] arg1_q,
	output logic [htc_pkg::DATA_W-1:0] arg2_q
);

	typedef enum logic [1:0] {
		U_START = 2'h0,
		U_RUN_HOLD = 2'h1,
		U_READY = 2'h3,
		U_ACK = 2'h2
	} htc_ust_t;

	htc_ust_t st_q;
	logic [1:0] hold_q;
	logic take;

	assign take = (st_q == U_READY) && (opcode_in != htc_pkg::OP_NOP);

	// ----------------------------------------
	// State and call status
	// ----------------------------------------

	// Status moves RESET/ACK -> RUN on request, RUN -> ACK on opcode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= U_START;
			call_status_q <= htc_pkg::CS_RESET;
			hold_q <= 2'h0;
		end else if (soft_rst) begin
			st_q <= U_START;
			call_status_q <= htc_pkg::CS_RESET;
			hold_q <= 2'h0;
		end else begin
			case (st_q)
				U_START, U_ACK: begin
					if (ureq == htc_pkg::UR_ASK_SET_RUN) begin
						st_q <= U_RUN_HOLD;
						call_status_q <= htc_pkg::CS_RUN;
						hold_q <= htc_pkg::RUN_HOLD_CYC;
					end
				end
				U_RUN_HOLD: begin
					hold_q <= hold_q - 2'h1;
					if (hold_q == 2'h1) begin
						st_q <= U_READY;
					end
				end
				U_READY: begin
					if (take) begin
						st_q <= U_ACK;
						call_status_q <= htc_pkg::CS_ACK;
					end
				end
				default: begin
					st_q <= U_START;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Opcode and argument capture
	// ----------------------------------------

	// Only this machine writes these registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			opcode_q <= htc_pkg::OP_NOP;
			arg1_q <= htc_pkg::WORD_RST;
			arg2_q <= htc_pkg::WORD_RST;
		end else if (soft_rst) begin
			opcode_q <= htc_pkg::OP_NOP;
		end else if (take) begin
			opcode_q <= opcode_in;
			arg1_q <= arg1_in;
			arg2_q <= arg2_in;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || soft_rst);

	sequence run_rise;
		(call_status_q == htc_pkg::CS_RUN) && ($past(call_status_q) != htc_pkg::CS_RUN);
	endsequence

	AST_RUN_HOLD_TWO: assert property (run_rise |-> (st_q == U_RUN_HOLD)[*2] ##1 (st_q == U_READY))
		else $error("opcode accepted too soon after RUN");
	AST_ACK_ON_OPCODE: assert property (take |=> call_status_q == htc_pkg::CS_ACK)
		else $error("opcode not acknowledged");
	AST_RESET_STAYS: assert property ((call_status_q == htc_pkg::CS_RESET && ureq == htc_pkg::UR_NOOP)
		|=> call_status_q == htc_pkg::CS_RESET)
		else $error("RESET left without RUN request");
	AST_OPCODE_KEPT: assert property ((!take && !soft_rst) |=> $stable(opcode_q) && $stable(arg1_q))
		else $error("opcode changed outside acceptance");

endmodule : htc_user_fsm

`default_nettype wire

// ### sim/htc_bus_model.sv
// Bus partner model: answers each master request after a set delay.
// Assumes one clock with the controller and one transfer at a time.

`default_nettype none

module htc_bus_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic master_req,
	input wire logic master_rnw,
	input wire logic [31:0] master_addr_out,
	input wire logic [31:0] master_wdata_out,
	input wire logic [31:0] rd_val,
	input var int dly,
	output logic master_ack,
	output logic [31:0] master_rdata_in,
	output int n_xfer,
	output logic [31:0] l_addr,
	output logic [31:0] l_wdata,
	output logic l_rnw
);
	timeunit 1ns;
	timeprecision 1ns;

	int wt;
	logic done;

	// Ack once per request after dly cycles; data is junk off the ack cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			master_ack <= 1'b0;
			master_rdata_in <= 32'hA5A5_A5A5;
			wt <= 0;
			done <= 1'b0;
			n_xfer <= 0;
		end else begin
			master_ack <= 1'b0;
			master_rdata_in <= ~master_rdata_in;
			if (!master_req) begin
				wt <= 0;
				done <= 1'b0;
			end else if (!done && wt >= dly) begin
				master_ack <= 1'b1;
				master_rdata_in <= rd_val;
				done <= 1'b1;
				n_xfer <= n_xfer + 1;
				l_addr <= master_addr_out;
				l_wdata <= master_wdata_out;
				l_rnw <= master_rnw;
			end else begin
				wt <= wt + 1;
			end
		end
	end
endmodule : htc_bus_model

`default_nettype wire

// ### sim/hw_thread_call_controller_tb.sv
// Bench for the call controller: drives system events and user opcodes.
// Assumes htc_pkg, htc_top and htc_bus_model are compiled first.

`default_nettype none

module hw_thread_call_controller_tb;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [31:0] FB = 32'h0001_0000;
	localparam logic [31:0] AB = 32'h0002_0000;
	localparam logic [31:0] RB = 32'h0003_0000;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic tid_wr = 1'b0;
	logic cmd_run = 1'b0;
	logic cmd_reset = 1'b0;
	logic [7:0] thread_ident_reg = 8'h00;
	logic [31:0] sys_arg_in = 32'h0;
	logic [5:0] user_opcode = 6'h00;
	logic [31:0] user_arg1 = 32'h0;
	logic [31:0] user_arg2 = 32'h0;
	logic cmd_ack, master_req, master_rnw, master_ack, user_rst, l_rnw;
	logic [31:0] master_addr_out, master_wdata_out, master_rdata_in, call_result, l_addr, l_wdata;
	htc_pkg::htc_sys_st_t sys_status;
	htc_pkg::htc_call_st_t call_status;
	logic [31:0] rd_val = 32'h0, exp_res, pr, a;
	logic [7:0] tid;
	logic [5:0] ops [3] = '{htc_pkg::OP_YIELD, htc_pkg::OP_INTR_ASSOC, 6'h3F};
	int dly = 0, n, n_xfer, err_total = 0, tests_run = 0;

	htc_top #(.FINISH_BASE(FB), .ACQUIRE_BASE(AB), .RELEASE_BASE(RB)) i_dut (.core_clk, .nrst, .tid_wr,
		.thread_ident_reg, .cmd_run, .cmd_reset, .sys_arg_in, .cmd_ack, .sys_status, .master_req, .master_rnw,
		.master_addr_out, .master_wdata_out, .master_rdata_in, .master_ack, .user_opcode, .user_arg1,
		.user_arg2, .call_status, .call_result, .user_rst);
	htc_bus_model i_bus (.clk(core_clk), .rst_n(nrst), .master_req, .master_rnw, .master_addr_out,
		.master_wdata_out, .rd_val, .dly, .master_ack, .master_rdata_in, .n_xfer, .l_addr, .l_wdata, .l_rnw);

	// Clock of 100 ns
	always #50 core_clk = ~core_clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [64:0] got, input logic [64:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		if (err_total == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	// Bounded wait on system or call status; pr keeps the result one cycle back
	task automatic wait_for(input bit sys, input logic [2:0] v);
		n = 0;
		pr = call_result;
		while ((sys ? sys_status : {1'b0, call_status}) !== v) begin
			pr = call_result;
			@(negedge core_clk);
			n++;
			if (n > 400) begin
				err_total++;
				stop_test();
			end
		end
	endtask : wait_for

	task automatic run_cmd();
		@(posedge core_clk);
		sys_arg_in <= exp_res;
		cmd_run <= 1'b1;
		@(posedge core_clk);
		cmd_run <= 1'b0;
		wait_for(0, 3'h1);
		chk(sys_status, htc_pkg::SS_RUNNING);
	endtask : run_cmd

	task automatic bring_up();
		tid = 8'($urandom);
		repeat (4) @(posedge core_clk);
		thread_ident_reg <= tid;
		tid_wr <= 1'b1;
		@(posedge core_clk);
		tid_wr <= 1'b0;
		wait_for(1, htc_pkg::SS_USED);
		chk(call_status, htc_pkg::CS_RESET);
		chk(user_rst, 1);
		exp_res = $urandom;
		// The controller leaves its USED wait two edges after the status shows; RUN before that is ignored
		repeat (2) @(posedge core_clk);
		run_cmd();
		chk(call_result, exp_res);
	endtask : bring_up

	// One user call; ss of zero means the call ends in RUN
	task automatic call(input logic [5:0] op, input logic [31:0] a1, input logic [31:0] a2, input int nb,
		input logic [2:0] ss);
		int b0;
		b0 = n_xfer;
		@(posedge core_clk);
		user_opcode <= op;
		user_arg1 <= a1;
		user_arg2 <= a2;
		wait_for(0, 3'h3);
		chk(n >= 3, 1);
		@(posedge core_clk);
		user_opcode <= htc_pkg::OP_NOP;
		wait_for(ss != 0, (ss != 0) ? ss : 3'h1);
		if (ss != 0)
			chk(call_status, htc_pkg::CS_ACK);
		if (op == htc_pkg::OP_SELF)
			chk(pr, exp_res);
		chk(n_xfer - b0, nb);
		chk(call_result, exp_res);
	endtask : call

	function automatic logic [31:0] ea(input logic [31:0] base, input logic [31:0] a1);
		ea = base | {16'h0000, a1[31:26], tid, 2'h0};
	endfunction : ea

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'hB077));
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		bring_up();
		a = $urandom;
		rd_val = $urandom;
		exp_res = rd_val;
		call(htc_pkg::OP_READ, a, 32'h0, 1, 3'h0);
		chk(l_addr, a);
		chk(l_rnw, 1);
		a = $urandom;
		rd_val = $urandom;
		dly = $urandom_range(5, 1);
		call(htc_pkg::OP_WRITE, a, ~a, 1, 3'h0);
		chk({l_rnw, l_addr, l_wdata}, {1'b0, a, ~a});
		exp_res = {24'h000000, tid};
		call(htc_pkg::OP_SELF, $urandom, $urandom, 0, 3'h0);
		foreach (ops[i])
			call(ops[i], $urandom, $urandom, 0, 3'h0);
		a = $urandom;
		call(htc_pkg::OP_UNLOCK, a, 32'h0, 1, 3'h0);
		chk(l_addr, ea(RB, a));
		rd_val = $urandom | 32'h1;
		call(htc_pkg::OP_LOCK, a, 32'h0, 1, 3'h0);
		chk(l_addr, ea(AB, a));
		chk(sys_status, htc_pkg::SS_RUNNING);
		rd_val = $urandom & 32'hFFFF_FFFE;
		dly = 0;
		call(htc_pkg::OP_LOCK, a, 32'h0, 1, htc_pkg::SS_BLOCKED);
		repeat (2) @(posedge core_clk);
		run_cmd();
		rd_val = $urandom;
		dly = 3;
		call(htc_pkg::OP_EXIT, $urandom, 32'h0, 1, htc_pkg::SS_EXITED);
		chk(l_addr, ea(FB, 32'h0));
		@(posedge core_clk);
		cmd_reset <= 1'b1;
		@(posedge core_clk);
		cmd_reset <= 1'b0;
		@(negedge core_clk);
		chk({cmd_ack, call_status}, {1'b1, htc_pkg::CS_ACK});
		repeat (2) @(negedge core_clk);
		chk({user_rst, call_status, sys_status}, {1'b1, htc_pkg::CS_RESET, htc_pkg::SS_NOT_USED});
		bring_up();
		call(htc_pkg::OP_EXIT_ERR, 32'h0, 32'h0, 1, htc_pkg::SS_EXIT_ERR);
		chk(l_addr, ea(FB, 32'h0));
		stop_test();
	end
endmodule : hw_thread_call_controller_tb

`default_nettype wire
